// ### logic/tac_alarm.sv
`timescale 1ns/1ps
`include "tac_defs.svh"
// Functional notes
// R1: alarm delay 0..10 s per channel, default 1 s
// R2: alarm counter counts down while tripped, back up when clear
// R3: alarm expiry drops alarm relay, amber indicator, flags source, logs
// R4: stop delay 0..60 s per channel, default 60 s
// R5: stop counter runs with alarm counter, recovers when trip clears
// R6: stop expiry drops stop relay, red indicator, flags source, logs
// R7: after alarm, show remaining stop count until stop or clear
// R8: eight base channels, six bearing and two ambient; twenty with boards
// R9: board one adds 8..13, board two 14..19, only when present
// R10: bearing enable per channel; 1..4 on, 5..6 off by default
// R11: absolute threshold 32..230, default 140
// R12: bearing reference off, ambient one or ambient two, default off
// R13: selecting a reference enables the referenced channel with defaults
// R14: relative alarm above reference plus setting 2..90, default 30
// R15: rate-of-rise switch per channel, default on
// R16: alarm relay held off while rise per minute exceeds limit 2.0..5.0
// R17: rate-of-rise suppressed during start-up delay
// R18: two ambient channels, default off, own settings
// R19: opposite mode: tail channels reference each other
// R20: channel in alarm shows red instead of green
// R21: counters move once per second tick, saturate at 0 and setting
// R22: trip is OR of absolute, relative and rise while enabled
module tac_alarm #(
	parameter int TICK_CYC = `TAC_TICK_CYC,
	parameter int ROR_WIN  = `TAC_MIN_CYC
) (
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic [`TAC_NUM_CH*8-1:0]    temp_in,
	input  wire logic [`TAC_NUM_CH-1:0]      chan_en_in,
	input  wire logic [`TAC_NUM_CH-1:0]      cfg_valid_in,
	input  wire logic                        exp_board_one_in,
	input  wire logic                        exp_board_two_in,
	input  wire logic [`TAC_NUM_CH*8-1:0]    abs_lim_in,
	input  wire logic [`TAC_NUM_CH*2-1:0]    ref_sel_in,
	input  wire logic [`TAC_NUM_CH*8-1:0]    rel_lim_in,
	input  wire logic [`TAC_NUM_CH-1:0]      ror_en_in,
	input  wire logic [`TAC_NUM_CH*8-1:0]    ror_lim_in,
	input  wire logic [`TAC_NUM_CH*4-1:0]    alm_dly_in,
	input  wire logic [`TAC_NUM_CH*6-1:0]    stp_dly_in,
	input  wire logic [7:0]                  ror_start_dly_in,
	output logic                             alarm_relay_out,
	output logic                             stop_relay_out,
	output logic                             alarm_led_amber_out,
	output logic                             stop_led_red_out,
	output logic [`TAC_NUM_CH-1:0]           chan_red_out,
	output logic [`TAC_NUM_CH-1:0]           alarm_src_out,
	output logic [`TAC_NUM_CH-1:0]           stop_src_out,
	output logic [`TAC_NUM_CH-1:0]           eff_en_out,
	output logic [5:0]                       stop_remain_out,
	output logic                             stop_remain_vld_out,
	output logic                             log_vld_out,
	output tac_pkg::tac_ev_t                 log_kind_out,
	output logic [4:0]                       log_chan_out
);
	localparam int N = `TAC_NUM_CH;
	logic         tick;
	logic [N-1:0] present;
	logic [N-1:0] ref_force;
	logic [N-1:0] eff_en;
	logic [N-1:0] trip;
	logic [N-1:0] alarm;
	logic [N-1:0] stop;
	logic [N-1:0] ror_hit;
	logic [N*6-1:0] stp_cnt;
	logic [N*8-1:0] eff_abs;
	logic [N*8-1:0] eff_rel;
	logic [N*8-1:0] eff_ror;
	logic [N*4-1:0] eff_alm;
	logic [N*6-1:0] eff_stp;
	// minute sampler: previous temp per channel, rise per minute in tenths
	logic [N*8-1:0] prev_ff;
	logic [N*8-1:0] nxt_prev;
	logic [N*8-1:0] rise_ff;
	logic [N*8-1:0] nxt_rise;
	logic [5:0]     sec_ff;
	logic [5:0]     nxt_sec;
	logic [7:0]     start_ff;
	logic [7:0]     nxt_start;
	logic           primed_ff;
	logic           nxt_primed;
	logic [N-1:0] alarm_ff;
	logic [N-1:0] nxt_alarm;
	logic [N-1:0] stop_ff;
	logic [N-1:0] nxt_stop;
	logic [N-1:0] alarm_lat_ff;
	logic [N-1:0] nxt_alarm_lat;
	logic [N-1:0] stop_lat_ff;
	logic [N-1:0] nxt_stop_lat;
	logic         log_vld_ff;
	logic         nxt_log_vld;
	tac_pkg::tac_ev_t log_kind_ff;
	tac_pkg::tac_ev_t nxt_log_kind;
	logic [4:0]   log_chan_ff;
	logic [4:0]   nxt_log_chan;
	logic [5:0]   remain_ff;
	logic [5:0]   nxt_remain;
	logic         remain_vld_ff;
	logic         nxt_remain_vld;
	tac_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tick_out (tick)
	);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			logic [7:0] t_own;
			logic [7:0] t_ref;
			logic [8:0] rel_lvl;
			logic       has_ref;
			logic       ref_is_l;
			tac_pkg::tac_ref_t sel;
			assign t_own = temp_in[g*8 +: 8];
			assign sel = tac_pkg::tac_ref_t'(ref_sel_in[g*2 +: 2]);
			if (g >= `TAC_IDX_BRD2_LO && g < `TAC_IDX_BRD2_LO + 6) begin : g_e2
				assign present[g] = exp_board_two_in; // R9
			end else if (g >= `TAC_IDX_BRD1_LO && g < `TAC_IDX_BRD2_LO) begin : g_e1
				assign present[g] = exp_board_one_in; // R9
			end else begin : g_base
				assign present[g] = 1'b1; // R8
			end
			// R12 R19 reference choice; opposite only on the tail pair
			always_comb begin
				has_ref = 1'b1;
				t_ref = 8'h00;
				ref_is_l = (5'(g) == `TAC_IDX_TAIL_R);
				case (sel)
					tac_pkg::TAC_REF_AMB_A: t_ref = temp_in[6*8 +: 8]; // R12
					tac_pkg::TAC_REF_AMB_B: t_ref = temp_in[7*8 +: 8]; // R12
					tac_pkg::TAC_REF_OPP: begin
						if (5'(g) == `TAC_IDX_TAIL_L)
							t_ref = temp_in[21*8 +: 8]; // R19
						else if (ref_is_l)
							t_ref = temp_in[20*8 +: 8]; // R19
						else
							has_ref = 1'b0;
					end
					default: has_ref = 1'b0;
				endcase
			end
			// settings fall back to defaults when not loaded (R13)
			assign eff_abs[g*8 +: 8] = cfg_valid_in[g]
				? abs_lim_in[g*8 +: 8] : `TAC_ABS_DEF; // R11
			assign eff_rel[g*8 +: 8] = cfg_valid_in[g]
				? rel_lim_in[g*8 +: 8] : `TAC_REL_DEF; // R14
			assign eff_ror[g*8 +: 8] = cfg_valid_in[g]
				? ror_lim_in[g*8 +: 8] : `TAC_ROR_DEF; // R16
			assign eff_alm[g*4 +: 4] = cfg_valid_in[g]
				? alm_dly_in[g*4 +: 4] : `TAC_ALM_DLY_DEF; // R1
			assign eff_stp[g*6 +: 6] = cfg_valid_in[g]
				? stp_dly_in[g*6 +: 6] : `TAC_STP_DLY_DEF; // R4
			assign eff_en[g] = present[g] && (chan_en_in[g] || ref_force[g]);
			assign rel_lvl = {1'b0, t_ref} + {1'b0, eff_rel[g*8 +: 8]};
			// R15 R16 R17 rise check, only with a primed minute sample
			assign ror_hit[g] = ror_en_in[g] && primed_ff
				&& (start_ff == 8'h00)
				&& (rise_ff[g*8 +: 8] > eff_ror[g*8 +: 8]);
			assign trip[g] = eff_en[g] && ( // R22
				(t_own > eff_abs[g*8 +: 8]) // R11
				|| (has_ref && {1'b0, t_own} > rel_lvl) // R14
				|| ror_hit[g]); // R16
			tac_chan u_chan (
				.clk_in      (clk_in),
				.rst_n_in    (rst_n_in),
				.tick_in     (tick),
				.trip_in     (trip[g]),
				.alm_dly_in  (eff_alm[g*4 +: 4]),
				.stp_dly_in  (eff_stp[g*6 +: 6]),
				.alarm_out   (alarm[g]),
				.stop_out    (stop[g]),
				.stp_cnt_out (stp_cnt[g*6 +: 6])
			);
		end
	endgenerate
	always_comb begin
		ref_force = '0;
		for (int i = 0; i < N; i++) begin
			if (chan_en_in[i] && present[i]) begin
				case (tac_pkg::tac_ref_t'(ref_sel_in[i*2 +: 2]))
					tac_pkg::TAC_REF_AMB_A: ref_force[6] = 1'b1; // R13
					tac_pkg::TAC_REF_AMB_B: ref_force[7] = 1'b1; // R13
					default: ;
				endcase
			end
		end
	end
	// rise in tenths per minute = 10 * delta; first window only primes
	always_comb begin
		nxt_prev = prev_ff;
		nxt_rise = rise_ff;
		nxt_sec = sec_ff;
		nxt_primed = primed_ff;
		nxt_start = start_ff;
		if (tick) begin
			if (start_ff != 8'h00) nxt_start = start_ff - 8'h01; // R17
			nxt_sec = sec_ff + 6'h01;
			if (sec_ff == 6'(ROR_WIN - 1)) begin
				nxt_sec = 6'h00;
				nxt_prev = temp_in;
				nxt_primed = 1'b1;
				for (int i = 0; i < N; i++) begin
					if (primed_ff && temp_in[i*8 +: 8] > prev_ff[i*8 +: 8])
						nxt_rise[i*8 +: 8] = 8'(((temp_in[i*8 +: 8]
							- prev_ff[i*8 +: 8]) > 8'h19) ? 8'hff
							: (temp_in[i*8 +: 8] - prev_ff[i*8 +: 8]) * 8'h0a);
					else
						nxt_rise[i*8 +: 8] = 8'h00;
				end
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			prev_ff <= '0;
			rise_ff <= '0;
			sec_ff <= 6'h00;
			primed_ff <= 1'b0;
			start_ff <= 8'hff;
		end else begin
			prev_ff <= nxt_prev;
			rise_ff <= nxt_rise;
			sec_ff <= nxt_sec;
			primed_ff <= nxt_primed;
			start_ff <= primed_ff ? nxt_start : ror_start_dly_in;
		end
	end
	// events, log and stop countdown display
	always_comb begin
		nxt_alarm = alarm;
		nxt_stop = stop;
		nxt_alarm_lat = alarm_lat_ff | alarm; // R3
		nxt_stop_lat = stop_lat_ff | stop; // R6
		nxt_log_vld = 1'b0;
		nxt_log_kind = log_kind_ff;
		nxt_log_chan = log_chan_ff;
		nxt_remain_vld = 1'b0;
		nxt_remain = 6'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (!trip[i]) begin
				nxt_alarm_lat[i] = 1'b0;
				nxt_stop_lat[i] = 1'b0;
			end
			if (alarm[i] && !alarm_ff[i]) begin
				nxt_log_vld = 1'b1; // R3
				nxt_log_kind = tac_pkg::TAC_EV_ALARM;
				nxt_log_chan = 5'(i);
			end
			if (alarm[i] && !stop[i]) begin
				nxt_remain_vld = 1'b1; // R7
				nxt_remain = stp_cnt[i*6 +: 6];
			end
		end
		// stop events take the log slot over alarm events
		for (int i = N - 1; i >= 0; i--) begin
			if (stop[i] && !stop_ff[i]) begin
				nxt_log_vld = 1'b1; // R6
				nxt_log_kind = tac_pkg::TAC_EV_STOP;
				nxt_log_chan = 5'(i);
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			alarm_ff <= '0;
			stop_ff <= '0;
			alarm_lat_ff <= '0;
			stop_lat_ff <= '0;
			log_vld_ff <= 1'b0;
			log_kind_ff <= tac_pkg::TAC_EV_ALARM;
			log_chan_ff <= 5'h00;
			remain_ff <= 6'h00;
			remain_vld_ff <= 1'b0;
		end else begin
			alarm_ff <= nxt_alarm;
			stop_ff <= nxt_stop;
			alarm_lat_ff <= nxt_alarm_lat;
			stop_lat_ff <= nxt_stop_lat;
			log_vld_ff <= nxt_log_vld;
			log_kind_ff <= nxt_log_kind;
			log_chan_ff <= nxt_log_chan;
			remain_ff <= nxt_remain;
			remain_vld_ff <= nxt_remain_vld;
		end
	end
	// relays energized (1) when healthy, de-energized on expiry
	assign alarm_relay_out = ~|alarm_ff; // R3 R16
	assign stop_relay_out = ~|stop_ff; // R6
	assign alarm_led_amber_out = |alarm_ff; // R3
	assign stop_led_red_out = |stop_ff; // R6
	assign chan_red_out = alarm_ff; // R20
	assign alarm_src_out = alarm_lat_ff;
	assign stop_src_out = stop_lat_ff;
	assign eff_en_out = eff_en; // R10 R18
	assign stop_remain_out = remain_ff; // R7
	assign stop_remain_vld_out = remain_vld_ff;
	assign log_vld_out = log_vld_ff;
	assign log_kind_out = log_kind_ff;
	assign log_chan_out = log_chan_ff;
	sequence s_alarm_rise(i);
		!alarm_ff[i] ##1 alarm_ff[i];
	endsequence
	relay_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|alarm |=> !alarm_relay_out && alarm_led_amber_out) // R3
		else $error("alarm relay not dropped");
	relay_stop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|stop |=> !stop_relay_out && stop_led_red_out) // R6
		else $error("stop relay not dropped");
	alarm_log_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_alarm_rise(0) |-> log_vld_out) // R3
		else $error("alarm event not logged");
	disabled_trip_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) (trip & ~eff_en) == '0) // R22
		else $error("disabled channel tripped");
	board_absent_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		!exp_board_one_in |-> eff_en[13:8] == 6'h00) // R9
		else $error("absent board channel enabled");
	ror_start_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_ff != 8'h00 |-> ror_hit == '0) // R17
		else $error("rise alarm during start-up");
	ror_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ror_hit & ~ror_en_in) == '0) // R15
		else $error("rise alarm while switched off");
	ref_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		chan_en_in[0] && ref_sel_in[1:0] == 2'h1 |-> eff_en[6]) // R13
		else $error("reference channel not enabled");
	red_state_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		alarm[0] |=> chan_red_out[0]) // R20
		else $error("channel not shown red");
	remain_show_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		alarm[0] && !stop[0] |=> stop_remain_vld_out) // R7
		else $error("stop countdown not shown");
endmodule : tac_alarm

// ### logic/tac_defs.svh
`ifndef TAC_DEFS_SVH
`define TAC_DEFS_SVH
// channel map: 0..5 bearing, 6..7 ambient, 8..13 board one, 14..19 board two,
// 20..21 tail rub-block pair
`define TAC_NUM_CH         22
`define TAC_IDX_AMB_A      5'h06
`define TAC_IDX_AMB_B      5'h07
`define TAC_IDX_BRD1_LO    8
`define TAC_IDX_BRD2_LO    14
`define TAC_IDX_TAIL_L     5'h14
`define TAC_IDX_TAIL_R     5'h15
`define TAC_ALM_DLY_MAX    4'ha
`define TAC_ALM_DLY_DEF    4'h1
`define TAC_STP_DLY_MAX    6'h3c
`define TAC_STP_DLY_DEF    6'h3c
`define TAC_ABS_DEF        8'h8c
`define TAC_ABS_MIN        8'h20
`define TAC_ABS_MAX        8'he6
`define TAC_REL_DEF        8'h1e
`define TAC_REL_MIN        8'h02
`define TAC_REL_MAX        8'h5a
`define TAC_ROR_DEF        8'h1e
`define TAC_ROR_MIN        8'h14
`define TAC_ROR_MAX        8'h32
`define TAC_EN_DEF         22'h00000f
`define TAC_TICK_NS        1000000000
`define TAC_CLK_NS         10
`define TAC_TICK_CYC       (`TAC_TICK_NS / `TAC_CLK_NS)
`define TAC_MIN_CYC        60
`endif

// ### logic/tac_pkg.sv
package tac_pkg;
	typedef enum logic [1:0] {
		TAC_REF_OFF,
		TAC_REF_AMB_A,
		TAC_REF_AMB_B,
		TAC_REF_OPP
	} tac_ref_t;
	typedef enum logic {
		TAC_EV_ALARM,
		TAC_EV_STOP
	} tac_ev_t;
endpackage : tac_pkg

// ### logic/tac_tick.sv
`timescale 1ns/1ps
`include "tac_defs.svh"
// one-cycle pulse every tick_cyc clock edges
module tac_tick #(
	parameter int TICK_CYC = `TAC_TICK_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	output logic      tick_out
);
	logic [29:0] cnt_ff;
	logic [29:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt = cnt_ff + 30'h1;
		if (cnt_ff == 30'(TICK_CYC - 1)) begin
			nxt_cnt = 30'h0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 30'h0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick_out = tick_ff;

	tick_spacing_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tick_ff |=> !tick_ff) else $error("tick lasted two cycles");
endmodule : tac_tick

// ### logic/tac_chan.sv
`timescale 1ns/1ps
`include "tac_defs.svh"
// per-channel cumulative alarm and stop delay counters
module tac_chan (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       tick_in,
	input  wire logic       trip_in,
	input  wire logic [3:0] alm_dly_in,
	input  wire logic [5:0] stp_dly_in,
	output logic            alarm_out,
	output logic            stop_out,
	output logic [5:0]      stp_cnt_out
);
	logic [3:0] alm_cnt_ff;
	logic [3:0] nxt_alm_cnt;
	logic [5:0] stp_cnt_ff;
	logic [5:0] nxt_stp_cnt;
	logic       init_ff;
	logic [3:0] alm_lim;
	logic [5:0] stp_lim;

	assign alm_lim = (alm_dly_in > `TAC_ALM_DLY_MAX) ? `TAC_ALM_DLY_MAX
		: alm_dly_in; // R1
	assign stp_lim = (stp_dly_in > `TAC_STP_DLY_MAX) ? `TAC_STP_DLY_MAX
		: stp_dly_in; // R4

	always_comb begin
		nxt_alm_cnt = alm_cnt_ff;
		nxt_stp_cnt = stp_cnt_ff;
		if (!init_ff) begin
			nxt_alm_cnt = alm_lim;
			nxt_stp_cnt = stp_lim;
		end else if (tick_in) begin
			if (trip_in) begin
				if (alm_cnt_ff != 4'h0) nxt_alm_cnt = alm_cnt_ff - 4'h1; // R2
				if (stp_cnt_ff != 6'h0) nxt_stp_cnt = stp_cnt_ff - 6'h1; // R5
			end else begin
				if (alm_cnt_ff < alm_lim) nxt_alm_cnt = alm_cnt_ff + 4'h1; // R21
				if (stp_cnt_ff < stp_lim) nxt_stp_cnt = stp_cnt_ff + 6'h1; // R21
			end
		end
		// a lowered setting clamps the count at once
		if (nxt_alm_cnt > alm_lim) nxt_alm_cnt = alm_lim;
		if (nxt_stp_cnt > stp_lim) nxt_stp_cnt = stp_lim;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			alm_cnt_ff <= 4'h0;
			stp_cnt_ff <= 6'h0;
			init_ff <= 1'b0;
		end else begin
			alm_cnt_ff <= nxt_alm_cnt;
			stp_cnt_ff <= nxt_stp_cnt;
			init_ff <= 1'b1;
		end
	end

	// zero delay expires as soon as the trip is seen
	assign alarm_out = init_ff && trip_in && (alm_cnt_ff == 4'h0); // R3
	assign stop_out = init_ff && trip_in && (stp_cnt_ff == 6'h0); // R6
	assign stp_cnt_out = stp_cnt_ff;

	cnt_down_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		init_ff && tick_in && trip_in && alm_cnt_ff != 4'h0
		&& $stable(alm_dly_in)
		|=> alm_cnt_ff == $past(alm_cnt_ff) - 4'h1) // R2
		else $error("alarm counter failed to count down");
	stop_down_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		init_ff && tick_in && trip_in && stp_cnt_ff != 6'h0
		&& $stable(stp_dly_in)
		|=> stp_cnt_ff == $past(stp_cnt_ff) - 6'h1) // R5
		else $error("stop counter failed to count down");
	cnt_sat_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		init_ff |-> alm_cnt_ff <= alm_lim && stp_cnt_ff <= stp_lim) // R21
		else $error("delay counter beyond its setting");
	cnt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		init_ff && !tick_in && $stable(alm_dly_in) && $stable(stp_dly_in)
		|=> $stable(alm_cnt_ff) && $stable(stp_cnt_ff)) // R21
		else $error("counter moved without tick");
endmodule : tac_chan

// ### test/tac_therm_model.sv
`timescale 1ns/1ps
`include "tac_defs.svh"
// thermistor readings seen by the alarm block, one byte per channel
module tac_therm_model (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     set_stb_in,
	input  wire logic [4:0]               set_ch_in,
	input  wire logic [7:0]               set_val_in,
	output logic      [`TAC_NUM_CH*8-1:0] temp_out
);
	// all sensors rest at a cool reading until the bench heats one
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			temp_out <= {`TAC_NUM_CH{8'h14}};
		else if (set_stb_in)
			temp_out[set_ch_in*8 +: 8] <= set_val_in;
	end
endmodule : tac_therm_model

// ### test/temperature_alarm_channels_bench.sv
`timescale 1ns/1ps
`include "tac_defs.svh"
module temperature_alarm_channels_bench;
	localparam int N = `TAC_NUM_CH;
	typedef struct {
		logic [4:0] ch;
		logic [1:0] rs;
		logic [4:0] oc;
		logic [7:0] ot;
		logic [7:0] t;
		logic [3:0] ad;
		logic [5:0] sd;
		logic       en;
		logic       bd;
		logic       ro;
		logic       ex;
	} tac_row_t;
	logic                     clk_in;
	logic                     rst_n_in;
	logic                     stb;
	logic [4:0]               sch;
	logic [7:0]               sval;
	logic [N*8-1:0]           temp_in;
	logic [N-1:0]             chan_en_in;
	logic [N-1:0]             cfg_valid_in;
	logic                     exp_board_one_in;
	logic                     exp_board_two_in;
	logic [N*8-1:0]           abs_lim_in;
	logic [N*2-1:0]           ref_sel_in;
	logic [N*8-1:0]           rel_lim_in;
	logic [N-1:0]             ror_en_in;
	logic [N*8-1:0]           ror_lim_in;
	logic [N*4-1:0]           alm_dly_in;
	logic [N*6-1:0]           stp_dly_in;
	logic [7:0]               ror_start_dly_in;
	logic                     alarm_relay_out;
	logic                     stop_relay_out;
	logic                     alarm_led_amber_out;
	logic                     stop_led_red_out;
	logic [N-1:0]             chan_red_out;
	logic [N-1:0]             alarm_src_out;
	logic [N-1:0]             stop_src_out;
	logic [N-1:0]             eff_en_out;
	logic [5:0]               stop_remain_out;
	logic                     stop_remain_vld_out;
	logic                     log_vld_out;
	tac_pkg::tac_ev_t         log_kind_out;
	logic [4:0]               log_chan_out;
	int                       mismatches;
	int                       samples_checked;
	tac_row_t                 r;
	logic                     ok;
	tac_row_t rows [12] = '{
		'{5'h00, 2'h0, 5'h00, 8'h14, 8'h96, 4'h1, 6'h02, 1'h1, 1'h0, 1'h0, 1'h1},
		'{5'h05, 2'h0, 5'h05, 8'h14, 8'h96, 4'h0, 6'h01, 1'h1, 1'h0, 1'h0, 1'h1},
		'{5'h06, 2'h0, 5'h06, 8'h14, 8'h96, 4'ha, 6'h0b, 1'h1, 1'h0, 1'h0, 1'h1},
		'{5'h09, 2'h0, 5'h09, 8'h14, 8'h96, 4'h2, 6'h03, 1'h1, 1'h1, 1'h0, 1'h1},
		'{5'h0f, 2'h0, 5'h0f, 8'h14, 8'h96, 4'h1, 6'h01, 1'h1, 1'h0, 1'h0, 1'h0},
		'{5'h03, 2'h0, 5'h03, 8'h14, 8'h96, 4'h1, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0},
		'{5'h00, 2'h1, 5'h06, 8'h32, 8'h55, 4'h1, 6'h02, 1'h1, 1'h0, 1'h0, 1'h1},
		'{5'h00, 2'h1, 5'h06, 8'h32, 8'h50, 4'h1, 6'h01, 1'h1, 1'h0, 1'h0, 1'h0},
		'{5'h02, 2'h2, 5'h07, 8'h32, 8'h55, 4'h1, 6'h02, 1'h1, 1'h0, 1'h0, 1'h1},
		'{5'h14, 2'h3, 5'h15, 8'h28, 8'h47, 4'h1, 6'h02, 1'h1, 1'h0, 1'h0, 1'h1},
		'{5'h01, 2'h0, 5'h01, 8'h14, 8'h28, 4'h1, 6'h02, 1'h1, 1'h0, 1'h1, 1'h1},
		'{5'h01, 2'h0, 5'h01, 8'h14, 8'h28, 4'h1, 6'h02, 1'h1, 1'h0, 1'h0, 1'h0}
	};

	tac_therm_model u_model (.clk_in, .rst_n_in, .set_stb_in(stb),
		.set_ch_in(sch), .set_val_in(sval), .temp_out(temp_in));

	tac_alarm #(.TICK_CYC(10), .ROR_WIN(4)) u_dut (.clk_in, .rst_n_in,
		.temp_in, .chan_en_in, .cfg_valid_in, .exp_board_one_in,
		.exp_board_two_in, .abs_lim_in, .ref_sel_in, .rel_lim_in, .ror_en_in,
		.ror_lim_in, .alm_dly_in, .stp_dly_in, .ror_start_dly_in,
		.alarm_relay_out, .stop_relay_out, .alarm_led_amber_out,
		.stop_led_red_out, .chan_red_out, .alarm_src_out, .stop_src_out,
		.eff_en_out, .stop_remain_out, .stop_remain_vld_out, .log_vld_out,
		.log_kind_out, .log_chan_out);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic set_t(input logic [4:0] c, input logic [7:0] v);
		@(negedge clk_in);
		stb = 1'b1;
		sch = c;
		sval = v;
		@(negedge clk_in);
		stb = 1'b0;
	endtask : set_t

	task automatic setup(input tac_row_t x);
		@(negedge clk_in);
		rst_n_in = 1'b0;
		chan_en_in = x.en ? (22'h1 << x.ch) : 22'h0;
		cfg_valid_in = '1;
		exp_board_one_in = x.bd;
		exp_board_two_in = x.bd;
		ref_sel_in = '0;
		ref_sel_in[x.ch*2 +: 2] = x.rs;
		alm_dly_in = {N{x.ad}};
		stp_dly_in = {N{x.sd}};
		ror_en_in = {N{x.ro}};
		repeat (10) @(negedge clk_in);
		chk("idle", 32'h6, {alarm_relay_out, stop_relay_out, log_vld_out});
		rst_n_in = 1'b1;
		if (x.oc != x.ch)
			set_t(x.oc, x.ot);
		repeat (3) @(negedge clk_in);
	endtask : setup

	task automatic run(input tac_row_t x);
		int n;
		int lo;
		int hi;
		if (x.ro)
			repeat (45) @(negedge clk_in); // first minute only primes
		set_t(x.ch, x.t);
		chk("eff_en", x.en && (x.ch < 8 || x.ch > 19 || x.bd), eff_en_out[x.ch]);
		if (x.rs == 2'h1 || x.rs == 2'h2)
			chk("ref_en", 32'h1, eff_en_out[5 + x.rs]);
		n = 0;
		while (alarm_relay_out !== 1'b0 && n < 400) begin
			@(negedge clk_in);
			n++;
		end
		lo = (x.ro || x.ad == 0) ? 0 : (x.ad - 1) * 10;
		hi = x.ad * 10 + (x.ro ? 120 : 4);
		if (!x.ex) begin
			chk("quiet", 32'h1, alarm_relay_out);
		end else begin
			chk("alarm_at", 32'h1, n >= lo && n <= hi);
			chk("alarm_out", {5'h1f, 1'b0, x.ch}, {alarm_led_amber_out, alarm_src_out[x.ch], chan_red_out[x.ch], log_vld_out, stop_remain_vld_out, log_kind_out, log_chan_out});
			chk("remain", x.sd - x.ad, stop_remain_out);
			while (stop_relay_out !== 1'b0 && n < 800) begin
				@(negedge clk_in);
				n++;
			end
			lo = (x.ro || x.sd == 0) ? 0 : (x.sd - 1) * 10;
			hi = x.sd * 10 + (x.ro ? 120 : 4);
			chk("stop_at", 32'h1, n >= lo && n <= hi);
			chk("stop_out", {4'he, 1'b1, x.ch}, {stop_led_red_out, stop_src_out[x.ch], log_vld_out, stop_remain_vld_out, log_kind_out, log_chan_out});
			set_t(x.ch, 8'h14);
			repeat (3) @(negedge clk_in);
			if (!x.ro)
				chk("clear", 32'hc, {alarm_relay_out, stop_relay_out, alarm_src_out[x.ch], stop_remain_vld_out});
		end
	endtask : run

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	initial begin
		#400000;
		mismatches++;
		close_out();
	end

	initial begin
		mismatches = 0;
		samples_checked = 0;
		rst_n_in = 1'b0;
		stb = 1'b0;
		sch = 5'h00;
		sval = 8'h14;
		chan_en_in = 22'h00000f;
		cfg_valid_in = '1;
		exp_board_one_in = 1'b0;
		exp_board_two_in = 1'b0;
		abs_lim_in = {N{8'h8c}};
		ref_sel_in = '0;
		rel_lim_in = {N{8'h1e}};
		ror_en_in = '0;
		ror_lim_in = {N{8'h1e}};
		alm_dly_in = {N{4'h1}};
		stp_dly_in = {N{6'h3c}};
		ror_start_dly_in = 8'h00;
		foreach (rows[i]) begin
			setup(rows[i]);
			run(rows[i]);
		end
		// defaults apply when per-channel settings are not valid
		r = rows[0];
		setup(r);
		@(negedge clk_in);
		rst_n_in = 1'b0;
		cfg_valid_in = '0;
		alm_dly_in = {N{4'h7}};
		stp_dly_in = {N{6'h05}};
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		r.ad = 4'h1;
		r.sd = 6'h3c;
		run(r);
		// short trips separated by recovery never reach the alarm
		r = rows[0];
		r.ad = 4'h3;
		r.sd = 6'h3c;
		setup(r);
		ok = 1'b1;
		for (int k = 0; k < 3; k++) begin
			set_t(5'h00, 8'h96);
			repeat (15) begin
				@(negedge clk_in);
				if (alarm_relay_out !== 1'b1 || stop_relay_out !== 1'b1)
					ok = 1'b0;
			end
			set_t(5'h00, 8'h14);
			repeat (45) @(negedge clk_in);
		end
		chk("count_back", 32'h1, ok);
		close_out();
	end
endmodule : temperature_alarm_channels_bench
